// ==== hdl/acs_pkg.sv ====
// Purpose: Shared constants and types for the converter selection and start control.
// Assumes: 100 MHz system clock; converter clock is a prescaled enable pulse.
// Notes:   Selection fields travel as one packed struct.
package acs_pkg;

  // ------------------------------------------------------------------
  // Widths and counts
  // ------------------------------------------------------------------
  localparam int unsigned CHAN_W   = 5;
  localparam int unsigned REF_W    = 2;
  localparam int unsigned RES_W    = 10;
  localparam int unsigned CNT_W    = 5;
  localparam int unsigned PRESC_W  = 7;
  localparam int unsigned PSEL_W   = 3;

  localparam logic [CNT_W-1:0] CONV_NORMAL = 5'h0D;
  localparam logic [CNT_W-1:0] CONV_FIRST  = 5'h19;
  // Ticks left when the bit decisions begin (one decision per result bit).
  localparam logic [CNT_W-1:0] DECIDE_LEAD = 5'h0B;

  // ------------------------------------------------------------------
  // Values
  // ------------------------------------------------------------------
  localparam logic [RES_W-1:0]   RES_RESET  = 10'h000;
  localparam logic [RES_W-1:0]   SAR_FIRST  = 10'h200;
  localparam logic [RES_W-1:0]   FULL_SCALE = 10'h3FF;
  localparam logic [3:0]         MSB_POS    = 4'h9;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 7'h00;

  typedef struct packed {
    logic [REF_W-1:0]  refsel;
    logic [CHAN_W-1:0] chan;
  } acs_sel_s;

  localparam acs_sel_s SEL_RESET = '{refsel: 2'h0, chan: 5'h00};

  typedef enum logic {
    ACS_IDLE = 1'b0,
    ACS_CONV = 1'b1
  } acs_state_e;

endpackage : acs_pkg

// ==== hdl/acs_prescaler.sv ====
// Purpose: Divides the system clock into one-cycle converter clock enables.
// Assumes: Counter runs only while the converter is enabled.
// Notes:   Restart clears the count so a trigger sees a fixed start delay.
`timescale 1ns/100ps
module acs_prescaler (
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  input  wire logic                        enable_i,
  input  wire logic                        restart_i,
  input  wire logic [acs_pkg::PSEL_W-1:0]  div_sel_i,
  output logic                             tick_o
);

  logic [acs_pkg::PRESC_W-1:0] count;
  logic [acs_pkg::PRESC_W-1:0] mask;

  // Division 2 for codes 0 and 1, otherwise two to the power of the code.
  function automatic logic [acs_pkg::PRESC_W-1:0] div_mask(
    input logic [acs_pkg::PSEL_W-1:0] sel);
    logic [acs_pkg::PRESC_W-1:0] m;
    m = 7'h01;
    for (int i = 2; i < 8; i++) begin
      if (sel >= 3'(i)) begin
        m[i-1] = 1'b1;
      end
    end
    return m;
  endfunction : div_mask

  assign mask = div_mask(div_sel_i);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= acs_pkg::PRESC_RESET;
    end else if (!enable_i || restart_i) begin
      count <= acs_pkg::PRESC_RESET;
    end else begin
      count <= count + 7'h01;
    end
  end

  assign tick_o = enable_i && !restart_i && ((count & mask) == mask);

endmodule : acs_prescaler

// ==== hdl/acs_core.sv ====
// Purpose: Channel/reference buffering, conversion start and sequencing, sleep start.
// Assumes: Comparator pin is asynchronous; all other inputs share clk_i.
// Notes:   Converter clock is a tick enable from the prescaler.
`timescale 1ns/100ps

module acs_core (
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  input  wire logic                        sel_wr_i,
  input  wire acs_pkg::acs_sel_s           sel_wdata_i,
  input  wire logic                        start_wr_i,
  input  wire logic                        converter_enable_i,
  input  wire logic                        auto_trigger_enable_i,
  input  wire logic                        free_run_i,
  input  wire logic                        trigger_i,
  input  wire logic [acs_pkg::PSEL_W-1:0]  prescale_sel_i,
  input  wire logic                        done_clr_i,
  input  wire logic                        done_int_en_i,
  input  wire logic                        sleep_halt_i,
  input  wire logic                        comparator_i,
  output acs_pkg::acs_sel_s                selection_register_o,
  output acs_pkg::acs_sel_s                sel_active_o,
  output logic                             conversion_start_bit_o,
  output logic                             conversion_done_flag_o,
  output logic                             done_irq_o,
  output logic                             busy_o,
  output logic [acs_pkg::RES_W-1:0]        result_o,
  output logic [acs_pkg::RES_W-1:0]        dac_code_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  acs_pkg::acs_state_e         state;
  acs_pkg::acs_sel_s           sel_tmp;
  acs_pkg::acs_sel_s           sel_act;
  logic                        start_bit;
  logic                        done_flag;
  logic                        irq;
  logic                        first_pending;
  logic [acs_pkg::CNT_W-1:0]   cnt;
  logic [acs_pkg::CNT_W-1:0]   conv_len;
  logic [acs_pkg::RES_W-1:0]   sar;
  logic [acs_pkg::RES_W-1:0]   result;
  logic [3:0]                  bitpos;
  logic                        cmp_meta;
  logic                        cmp_sync;
  logic                        trig_q;
  logic                        halt_q;
  logic                        tick;
  logic                        trig_edge;
  logic                        sleep_start;
  logic                        conv_start;
  logic                        done_evt;
  logic                        last_cycle;
  logic                        lock;
  logic                        decide;
  logic                        restart_free;
  logic [acs_pkg::RES_W-1:0]   next_sar;

  acs_prescaler u_presc (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .enable_i  (converter_enable_i),
    .restart_i (trig_edge),
    .div_sel_i (prescale_sel_i),
    .tick_o    (tick)
  );

  // ------------------------------------------------------------------
  // Input capture
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= comparator_i;
      cmp_sync <= cmp_meta;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      trig_q <= trigger_i;
      halt_q <= sleep_halt_i;
    end
  end

  // Busy edges never start anything; the prescaler restart is gated the same way.
  assign trig_edge = auto_trigger_enable_i && converter_enable_i && trigger_i && !trig_q
                     && (state == acs_pkg::ACS_IDLE) && !start_bit;
  // Sleep start only in single mode with the completion interrupt enabled.
  assign sleep_start = sleep_halt_i && !halt_q && converter_enable_i && !auto_trigger_enable_i
                       && done_int_en_i && (state == acs_pkg::ACS_IDLE) && !start_bit;

  // ------------------------------------------------------------------
  // Conversion sequencing
  // ------------------------------------------------------------------
  assign conv_len   = first_pending ? acs_pkg::CONV_FIRST : acs_pkg::CONV_NORMAL;
  assign conv_start = tick && start_bit && (state == acs_pkg::ACS_IDLE);
  assign last_cycle = (state == acs_pkg::ACS_CONV) && (cnt == conv_len - 5'h01);
  assign done_evt   = tick && last_cycle;
  assign lock       = (state == acs_pkg::ACS_CONV) && !last_cycle;
  assign decide     = tick && (state == acs_pkg::ACS_CONV)
                      && (cnt >= conv_len - acs_pkg::DECIDE_LEAD) && !last_cycle;
  assign restart_free = auto_trigger_enable_i && free_run_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= acs_pkg::ACS_IDLE;
      cnt   <= '0;
    end else if (!converter_enable_i) begin
      state <= acs_pkg::ACS_IDLE;
      cnt   <= '0;
    end else if (conv_start || (done_evt && restart_free)) begin
      state <= acs_pkg::ACS_CONV;
      cnt   <= '0;
    end else if (done_evt) begin
      state <= acs_pkg::ACS_IDLE;
      cnt   <= '0;
    end else if (tick && (state == acs_pkg::ACS_CONV)) begin
      cnt <= cnt + 5'h01;
    end
  end

  // The long initialising conversion follows every enable rising edge.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_pending <= 1'b1;
    end else if (!converter_enable_i) begin
      first_pending <= 1'b1;
    end else if (done_evt) begin
      first_pending <= 1'b0;
    end
  end

  // Start bit reads one for the whole conversion, however it began.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_bit <= 1'b0;
    end else if (!converter_enable_i) begin
      start_bit <= 1'b0;
    end else if (start_wr_i || trig_edge || sleep_start) begin
      start_bit <= 1'b1;
    end else if (done_evt && !restart_free) begin
      start_bit <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Successive approximation
  // ------------------------------------------------------------------
  // An input above reference keeps every trial bit, landing on full scale.
  always_comb begin
    next_sar = sar;
    if (!cmp_sync) begin
      next_sar[bitpos] = 1'b0;
    end
    if (bitpos != 4'h0) begin
      next_sar[bitpos - 4'h1] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sar    <= acs_pkg::SAR_FIRST;
      bitpos <= acs_pkg::MSB_POS;
    end else if (conv_start || done_evt) begin
      sar    <= acs_pkg::SAR_FIRST;
      bitpos <= acs_pkg::MSB_POS;
    end else if (decide) begin
      sar    <= next_sar;
      bitpos <= (bitpos == 4'h0) ? 4'h0 : bitpos - 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result <= acs_pkg::RES_RESET;
    end else if (done_evt) begin
      result <= sar;
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_flag <= 1'b0;
    end else if (done_evt) begin
      done_flag <= 1'b1;
    end else if (done_clr_i) begin
      done_flag <= 1'b0;
    end
  end

  // Request stands while the flag is set, so an earlier wake does not lose it.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq <= 1'b0;
    end else begin
      irq <= (done_flag || done_evt) && done_int_en_i;
    end
  end

  // ------------------------------------------------------------------
  // Selection buffering
  // ------------------------------------------------------------------
  // Sleep halt input only starts conversions: only the enable stops the converter.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_tmp <= acs_pkg::SEL_RESET;
    end else if (sel_wr_i) begin
      sel_tmp <= sel_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_act <= acs_pkg::SEL_RESET;
    end else if (!lock) begin
      sel_act <= sel_tmp;
    end
  end

  assign selection_register_o   = sel_tmp;
  assign sel_active_o           = sel_act;
  assign conversion_start_bit_o = start_bit;
  assign conversion_done_flag_o = done_flag;
  assign done_irq_o             = irq;
  assign busy_o                 = state;
  assign result_o               = result;
  assign dac_code_o             = sar;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [acs_pkg::CNT_W-1:0] ticks_seen;
  logic                      all_high;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ticks_seen <= '0;
      all_high   <= 1'b1;
    end else if (conv_start || done_evt) begin
      ticks_seen <= '0;
      all_high   <= 1'b1;
    end else begin
      if (tick && (state == acs_pkg::ACS_CONV)) begin
        ticks_seen <= ticks_seen + 5'h01;
      end
      if (decide && !cmp_sync) begin
        all_high <= 1'b0;
      end
    end
  end

  sequence s_done_shown;
    done_evt ##1 (done_flag && (result == $past(sar)));
  endsequence

  AST_COPY_IDLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !lock |=> sel_act == $past(sel_tmp)) else $error("active selection not mirrored");
  AST_LOCK_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (lock && $past(lock)) |-> $stable(sel_act)) else $error("selection moved while locked");
  AST_RESUME: assert property (@(posedge clk_i) disable iff (!nrst_i)
    done_evt |-> !lock) else $error("lock held into done cycle");
  AST_START_TICK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (start_bit && (state == acs_pkg::ACS_IDLE) && !tick) |=> state == acs_pkg::ACS_IDLE)
    else $error("conversion began off tick");
  AST_FREE_RUN: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (done_evt && restart_free && converter_enable_i) |=> (busy_o && start_bit))
    else $error("free run did not restart");
  AST_FULL_SCALE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (done_evt && all_high) |=> result == acs_pkg::FULL_SCALE) else $error("not full scale");
  AST_SLEEP_START: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sleep_start |=> start_bit) else $error("sleep start missed");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (done_evt && done_int_en_i) |=> irq) else $error("completion request missing");
  AST_DONE_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
    done_evt |-> s_done_shown) else $error("result or flag not stored");
  AST_SINGLE_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (done_evt && !restart_free && !start_wr_i) |=> !start_bit) else $error("start not cleared");
  AST_LENGTH: assert property (@(posedge clk_i) disable iff (!nrst_i)
    done_evt |-> ticks_seen == conv_len - 5'h01) else $error("conversion length wrong");
  AST_TRIG_IGNORE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (busy_o && !done_evt && converter_enable_i) |-> !trig_edge) else $error("busy edge taken");

endmodule : acs_core

// ==== verif/acs_analog_model.sv ====
// Purpose: Analog pins and comparator on the far side of the converter core.
// Assumes: Pin levels are 11-bit codes; above 10'h3FF lies over the reference.
// Notes:   The comparator is ideal and answers at once.
`timescale 1ns/100ps
module acs_analog_model (
  input  wire acs_pkg::acs_sel_s         sel_active_i,
  input  wire logic [acs_pkg::RES_W-1:0] dac_code_i,
  output logic                           comparator_o
);
  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  logic [10:0] pin [32];

  initial begin
    foreach (pin[i]) pin[i] = 11'h000;
  end

  task automatic set_pin(input int ch, input logic [10:0] v);
    pin[ch] = v;
  endtask : set_pin

  // Only the active selection reaches the comparator, so a leak of the
  // temporary copy into sampling shows up as a wrong result.
  assign comparator_o = (pin[sel_active_i.chan] >= {1'b0, dac_code_i});
endmodule : acs_analog_model

// ==== verif/tb_adc_select_buffer_sleep_start.sv ====
// Purpose: Self-checking bench for the selection buffer and start control.
// Assumes: Prescaler fixed at divide by 8; comparator from the analog model.
// Notes:   Expected codes and lengths are computed here, never read back.
`timescale 1ns/100ps
module tb_adc_select_buffer_sleep_start;
  // ----------------------------------------
  // Signals and checking
  // ----------------------------------------
  localparam int DIV   = 8;
  localparam int LIMIT = 20000;
  logic clk_i, nrst_i, sel_wr_i, start_wr_i, converter_enable_i, trigger_i;
  logic auto_trigger_enable_i, free_run_i, done_clr_i, done_int_en_i;
  logic sleep_halt_i, comp, start_bit, done_flag, irq, busy;
  acs_pkg::acs_sel_s sel_wdata_i, sel_reg, sel_act, s;
  logic [9:0] result, dac;
  logic [10:0] v;
  logic [10:0] corner [3] = '{11'h000, 11'h3FF, 11'h7FF};
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  int tm;

  acs_core DUT (.clk_i(clk_i), .nrst_i(nrst_i), .sel_wr_i(sel_wr_i),
    .sel_wdata_i(sel_wdata_i), .start_wr_i(start_wr_i),
    .converter_enable_i(converter_enable_i), .auto_trigger_enable_i(auto_trigger_enable_i),
    .free_run_i(free_run_i), .trigger_i(trigger_i), .prescale_sel_i(3'h3),
    .done_clr_i(done_clr_i), .done_int_en_i(done_int_en_i), .sleep_halt_i(sleep_halt_i),
    .comparator_i(comp), .selection_register_o(sel_reg), .sel_active_o(sel_act),
    .conversion_start_bit_o(start_bit), .conversion_done_flag_o(done_flag),
    .done_irq_o(irq), .busy_o(busy), .result_o(result), .dac_code_o(dac));

  acs_analog_model PART (.sel_active_i(sel_act), .dac_code_i(dac), .comparator_o(comp));

  always #5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_vec(input string what, input logic [9:0] exp, input logic [9:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec

  task automatic chk_sel(input string what, input acs_pkg::acs_sel_s exp,
                         input acs_pkg::acs_sel_s got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_sel

  task automatic chk_int(input string what, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_int

  function automatic logic [9:0] exp_code(input logic [10:0] lvl);
    return (lvl > 11'h3FF) ? 10'h3FF : lvl[9:0];
  endfunction : exp_code

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      step(1);
      n++;
    end
    chk_bit("busy level", lvl, busy);
  endtask : wait_busy

  task automatic wait_flag;
    int n;
    n = 0;
    while (done_flag !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    chk_bit("done flag set", 1'b1, done_flag);
  endtask : wait_flag

  task automatic wr_sel(input acs_pkg::acs_sel_s ns);
    @(posedge clk_i);
    sel_wr_i <= 1'b1;
    sel_wdata_i <= ns;
    @(posedge clk_i);
    sel_wr_i <= 1'b0;
  endtask : wr_sel

  task automatic clr_flag;
    @(posedge clk_i);
    done_clr_i <= 1'b1;
    @(posedge clk_i);
    done_clr_i <= 1'b0;
    step(1);
    chk_bit("done flag cleared", 1'b0, done_flag);
  endtask : clr_flag

  task automatic do_conv(input int len, input logic [9:0] exp, input logic mid,
                         input acs_pkg::acs_sel_s nsel);
    acs_pkg::acs_sel_s old;
    int t0;
    old = sel_act;
    @(posedge clk_i);
    start_wr_i <= 1'b1;
    @(posedge clk_i);
    start_wr_i <= 1'b0;
    step(1);
    chk_bit("start bit set", 1'b1, start_bit);
    wait_busy(1'b1, DIV + 2);
    t0 = cyc;
    if (mid) begin
      step(DIV);
      wr_sel(nsel);
      step(2);
      chk_sel("locked selection", old, sel_act);
    end
    wait_busy(1'b0, 400);
    chk_int("conversion cycles", len * DIV, cyc - t0);
    chk_bit("start bit cleared", 1'b0, start_bit);
    chk_vec("result", exp, result);
    chk_sel("active after done", nsel, sel_act);
    chk_bit("irq masked", 1'b0, irq);
    clr_flag();
  endtask : do_conv

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {clk_i, nrst_i, sel_wr_i, start_wr_i, converter_enable_i, trigger_i} = '0;
    {auto_trigger_enable_i, free_run_i, done_clr_i, done_int_en_i, sleep_halt_i} = '0;
    sel_wdata_i = '0;
    void'($urandom(32'h8140));
    repeat (12) @(posedge clk_i);
    #1;
    chk_vec("idle trial code", 10'h200, dac);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    converter_enable_i <= 1'b1;
    PART.set_pin(3, 11'h155);
    wr_sel('{2'h1, 5'h03});
    step(2);
    chk_sel("mirror idle", '{2'h1, 5'h03}, sel_act);
    do_conv(25, 10'h155, 1'b1, '{2'h3, 5'h05});
    for (int i = 0; i < 9; i++) begin
      // Single-ended channels only; the ideal model has no settling after a reference change.
      s.chan = 5'($urandom_range(7, 0));
      s.refsel = 2'($urandom_range(3, 0));
      v = (i < 3) ? corner[i] : 11'($urandom_range(2047, 0));
      PART.set_pin(s.chan, v);
      wr_sel(s);
      step(2);
      chk_sel("temporary copy", s, sel_reg);
      chk_sel("mirror idle", s, sel_act);
      do_conv(13, exp_code(v), 1'b0, s);
    end
    @(posedge clk_i);
    converter_enable_i <= 1'b0;
    step(3);
    @(posedge clk_i);
    converter_enable_i <= 1'b1;
    do_conv(25, exp_code(v), 1'b0, s);
    // Auto trigger: a second edge inside the conversion must be dropped.
    @(posedge clk_i);
    auto_trigger_enable_i <= 1'b1;
    trigger_i <= 1'b1;
    step(1);
    chk_bit("trigger start bit", 1'b1, start_bit);
    tm = cyc;
    wait_busy(1'b1, DIV + 2);
    chk_int("trigger to start", DIV, cyc - tm);
    @(posedge clk_i);
    trigger_i <= 1'b0;
    @(posedge clk_i);
    trigger_i <= 1'b1;
    wait_flag();
    clr_flag();
    step(200);
    chk_bit("busy edge ignored", 1'b0, busy);
    chk_bit("no second done", 1'b0, done_flag);
    // Free running: a change after completion lands one conversion late.
    PART.set_pin(1, 11'h0AA);
    PART.set_pin(2, 11'h321);
    @(posedge clk_i);
    trigger_i <= 1'b0;
    free_run_i <= 1'b1;
    wr_sel('{2'h1, 5'h01});
    @(posedge clk_i);
    start_wr_i <= 1'b1;
    @(posedge clk_i);
    start_wr_i <= 1'b0;
    wait_flag();
    tm = cyc;
    chk_vec("free run first", 10'h0AA, result);
    wr_sel('{2'h1, 5'h02});
    step(1);
    chk_bit("free run restarted", 1'b1, busy);
    chk_bit("free run start bit held", 1'b1, start_bit);
    clr_flag();
    wait_flag();
    chk_int("free run period", 13 * DIV, cyc - tm);
    chk_vec("free run old channel", 10'h0AA, result);
    clr_flag();
    wait_flag();
    chk_vec("free run new channel", 10'h321, result);
    @(posedge clk_i);
    auto_trigger_enable_i <= 1'b0;
    free_run_i <= 1'b0;
    clr_flag();
    wait_flag();
    clr_flag();
    // Sleep start: refused without the interrupt, then taken with it.
    @(posedge clk_i);
    sleep_halt_i <= 1'b1;
    step(40);
    chk_bit("sleep start refused", 1'b0, busy);
    @(posedge clk_i);
    sleep_halt_i <= 1'b0;
    done_int_en_i <= 1'b1;
    @(posedge clk_i);
    sleep_halt_i <= 1'b1;
    step(1);
    wait_busy(1'b1, DIV + 4);
    @(posedge clk_i);
    sleep_halt_i <= 1'b0;
    wait_flag();
    step(1);
    chk_bit("completion irq", 1'b1, irq);
    chk_vec("sleep result", 10'h321, result);
    clr_flag();
    step(1);
    chk_bit("irq after clear", 1'b0, irq);
    finish_test();
  end
endmodule : tb_adc_select_buffer_sleep_start
